// >>> hw/tcc_params.svh
// Register indices, field positions, reset values and sample counts for the timer block
`ifndef TCC_PARAMS_SVH
`define TCC_PARAMS_SVH

// Register indices; the APB byte address is four times the index
`define TCC_IDX_CTRL_A    8'h2f
`define TCC_IDX_CTRL_B    8'h2e
`define TCC_IDX_CNT_H     8'h2d
`define TCC_IDX_CNT_L     8'h2c
`define TCC_IDX_OCA_H     8'h2b
`define TCC_IDX_OCA_L     8'h2a
`define TCC_IDX_OCB_H     8'h29
`define TCC_IDX_OCB_L     8'h28
`define TCC_IDX_CAP_H     8'h25
`define TCC_IDX_CAP_L     8'h24
`define TCC_IDX_PINDIR    8'h31
`define TCC_IDX_FLAGS     8'h38
`define TCC_IDX_MASK      8'h39
`define TCC_IDX_CPUFLAGS  8'h3f

// Writable bit masks; all other positions read as zero
`define TCC_CTRL_A_WMASK  8'hf3
`define TCC_CTRL_B_WMASK  8'hdf
`define TCC_MASK_WMASK    8'hea
`define TCC_FLAGS_WMASK   8'hea
`define TCC_PINDIR_WMASK  8'h03
`define TCC_CPUFLAGS_WMASK 8'h80
`define TCC_RESET_BYTE    8'h00

// Bit positions shared by the mask and flag registers, plus the global enable bit
`define TCC_BIT_WIDE_OVF   7
`define TCC_BIT_MATCH_A    6
`define TCC_BIT_MATCH_B    5
`define TCC_BIT_CAPTURE    3
`define TCC_BIT_NARROW_OVF 1
`define TCC_BIT_GIE        7

// First control register fields
`define TCC_A_ACT_HI      7
`define TCC_A_ACT_LO      6
`define TCC_B_ACT_HI      5
`define TCC_B_ACT_LO      4
`define TCC_MODE_HI       1
`define TCC_MODE_LO       0

// Second control register fields
`define TCC_NC_BIT        7
`define TCC_EDGE_BIT      6
`define TCC_ACSEL_BIT     4
`define TCC_CTC_BIT       3
`define TCC_CS_HI         2
`define TCC_CS_LO         0

// Counter tops and capture filter length
`define TCC_TOP_8         16'h00ff
`define TCC_TOP_9         16'h01ff
`define TCC_TOP_10        16'h03ff
`define TCC_TOP_16        16'hffff
`define TCC_NC_SAMPLES    4
`define TCC_PRE_W         10

`endif

// >>> hw/tcc_pkg.sv
// Types shared by the timer compare/capture block
`default_nettype none
package tcc_pkg;
   typedef enum logic [1:0] {
      TCC_UP   = 2'b01,
      TCC_DOWN = 2'b10
   } tcc_dir_t;

   typedef enum logic [1:0] {
      TCC_PWM_OFF = 2'h0,
      TCC_PWM_8   = 2'h1,
      TCC_PWM_9   = 2'h2,
      TCC_PWM_10  = 2'h3
   } tcc_mode_t;

   typedef enum logic [1:0] {
      TCC_ACT_NONE   = 2'h0,
      TCC_ACT_TOGGLE = 2'h1,
      TCC_ACT_LOW    = 2'h2,
      TCC_ACT_HIGH   = 2'h3
   } tcc_act_t;
endpackage : tcc_pkg
`default_nettype wire

// >>> hw/tcc_sample_filter.sv
// Input sampler with two-flop synchroniser and optional equal-sample filter
`default_nettype none
module tcc_sample_filter #(
   parameter int DEPTH = 4
) (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic din,
   input  wire logic filter_en,
   output logic      level_out
);
   logic             sync1_reg;
   logic             sync2_reg;
   logic [DEPTH-1:0] hist_reg;
   logic             all_high;
   logic             all_low;

   assign all_high = &hist_reg;
   assign all_low  = ~|hist_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         hist_reg  <= '0;
      end else begin
         sync1_reg <= din;
         sync2_reg <= sync1_reg;
         hist_reg  <= {hist_reg[DEPTH-2:0], sync2_reg};
      end
   end

   // Filter on: level moves only on equal samples; filter off: it follows the synchroniser
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         level_out <= 1'b0;
      end else if (!filter_en) begin
         level_out <= sync2_reg;
      end else if (all_high || all_low) begin
         level_out <= hist_reg[0];
      end
   end
endmodule : tcc_sample_filter
`default_nettype wire

// >>> hw/tcc_timer1_ctrl.sv
// Sixteen-bit timer with two compares, input capture, centred PWM and interrupt gating
//
// The implementer's own choice: the APB slave port.
`include "tcc_params.svh"
`default_nettype none
// Contract
// - Wide overflow irq needs mask bit 7
// - Match A irq needs mask bit 6
// - Match B irq needs mask bit 5
// - Capture irq needs mask bit 3
// - Narrow overflow irq needs mask bit 1
// - Reserved bits always read zero
// - External count pin sampled each clock
// - Compare both channels, optional clear on A
// - Mode field selects off/8/9/10-bit PWM
// - PWM pulses centred and glitch free
// - Capture copies counter on selected edge
// - Comparator may trigger capture instead
// - Noise canceller needs four equal samples
// - Non-PWM actions: none/toggle/low/high
// - Pin driven only when direction is output
// - PWM mode uses its own action meaning
// - Sixteen-bit access through staging byte
// - Counting resumes from written value
module tcc_timer1_ctrl
   import tcc_pkg::*;
#(
   parameter int NC_DEPTH = `TCC_NC_SAMPLES
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [9:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        external_count_pin,
   input  wire logic        capture_input_pin,
   input  wire logic        comparator_out,
   input  wire logic        narrow_timer_overflow_evt,
   output logic             match_a_pin_out,
   output logic             match_a_pin_oe_n,
   output logic             match_b_pin_out,
   output logic             match_b_pin_oe_n,
   output logic             irq_wide_ovf,
   output logic             irq_match_a,
   output logic             irq_match_b,
   output logic             irq_capture,
   output logic             irq_narrow_ovf
);
   logic [7:0]           ctrl_a_reg;
   logic [7:0]           ctrl_b_reg;
   logic [7:0]           mask_reg;
   logic [7:0]           flags_reg;
   logic [7:0]           flags_next;
   logic [7:0]           pindir_reg;
   logic                 gie_reg;
   logic [7:0]           temp_reg;
   logic [7:0]           rd_hi_reg;
   logic [15:0]          cnt_reg;
   logic [15:0]          cnt_next;
   logic [15:0]          oca_reg;
   logic [15:0]          ocb_reg;
   logic [15:0]          oca_buf_reg;
   logic [15:0]          ocb_buf_reg;
   logic [15:0]          cap_reg;
   logic [`TCC_PRE_W-1:0] pre_reg;
   tcc_dir_t             dir_reg;
   tcc_dir_t             dir_next;
   logic                 oa_reg;
   logic                 ob_reg;
   logic                 ext_prev_reg;
   logic                 cap_prev_reg;

   // APB decode
   wire       setup  = psel & ~penable;
   wire       access = psel & penable;
   wire       wr     = access & pwrite;
   wire       rd     = access & ~pwrite;
   wire [7:0] idx    = paddr[9:2];
   wire [7:0] wbyte  = pwdata[7:0];

   wire hit_ctrl_a = (idx == `TCC_IDX_CTRL_A);
   wire hit_ctrl_b = (idx == `TCC_IDX_CTRL_B);
   wire hit_cnt_h  = (idx == `TCC_IDX_CNT_H);
   wire hit_cnt_l  = (idx == `TCC_IDX_CNT_L);
   wire hit_oca_h  = (idx == `TCC_IDX_OCA_H);
   wire hit_oca_l  = (idx == `TCC_IDX_OCA_L);
   wire hit_ocb_h  = (idx == `TCC_IDX_OCB_H);
   wire hit_ocb_l  = (idx == `TCC_IDX_OCB_L);
   wire hit_cap_h  = (idx == `TCC_IDX_CAP_H);
   wire hit_cap_l  = (idx == `TCC_IDX_CAP_L);
   wire hit_pindir = (idx == `TCC_IDX_PINDIR);
   wire hit_flags  = (idx == `TCC_IDX_FLAGS);
   wire hit_mask   = (idx == `TCC_IDX_MASK);
   wire hit_cpufl  = (idx == `TCC_IDX_CPUFLAGS);
   wire mapped = hit_ctrl_a | hit_ctrl_b | hit_cnt_h | hit_cnt_l | hit_oca_h | hit_oca_l
               | hit_ocb_h | hit_ocb_l | hit_cap_h | hit_cap_l | hit_pindir | hit_flags
               | hit_mask | hit_cpufl;

   // No wait states; read data is captured in the setup cycle
   assign pready  = 1'b1;
   assign pslverr = access & ~mapped;

   // High-byte write parks in staging, low write commits
   wire        wr_cnt_l  = wr & hit_cnt_l;
   wire        wr_oca_l  = wr & hit_oca_l;
   wire        wr_ocb_l  = wr & hit_ocb_l;
   wire        wr_high   = wr & (hit_cnt_h | hit_oca_h | hit_ocb_h);
   wire        rd_lo_lat = rd & (hit_cnt_l | hit_cap_l);
   wire [15:0] wr_word   = {temp_reg, wbyte};

   // Control fields
   wire [1:0]  mode_f  = ctrl_a_reg[`TCC_MODE_HI:`TCC_MODE_LO];
   wire [1:0]  act_a   = ctrl_a_reg[`TCC_A_ACT_HI:`TCC_A_ACT_LO];
   wire [1:0]  act_b   = ctrl_a_reg[`TCC_B_ACT_HI:`TCC_B_ACT_LO];
   wire [2:0]  cs_f    = ctrl_b_reg[`TCC_CS_HI:`TCC_CS_LO];
   wire        ctc_en  = ctrl_b_reg[`TCC_CTC_BIT];
   wire        pwm_on  = (mode_f != TCC_PWM_OFF);

   // Mode field picks the PWM top
   logic [15:0] top;
   always_comb begin
      case (mode_f)
         TCC_PWM_8:  top = `TCC_TOP_8;
         TCC_PWM_9:  top = `TCC_TOP_9;
         TCC_PWM_10: top = `TCC_TOP_10;
         default:    top = `TCC_TOP_16;
      endcase
   end

   // External count pin sampled and edge-detected
   logic ext_lvl;
   tcc_sample_filter #(.DEPTH(NC_DEPTH)) u_ext_sync (
      .pclk      (pclk),
      .presetn   (presetn),
      .din       (external_count_pin),
      .filter_en (1'b0),
      .level_out (ext_lvl)
   );
   wire ext_rise = ext_lvl & ~ext_prev_reg;
   wire ext_fall = ~ext_lvl & ext_prev_reg;

   // Comparator may replace the capture pin
   wire cap_src = ctrl_b_reg[`TCC_ACSEL_BIT] ? comparator_out : capture_input_pin;
   logic cap_lvl;
   tcc_sample_filter #(.DEPTH(NC_DEPTH)) u_cap_filt (
      .pclk      (pclk),
      .presetn   (presetn),
      .din       (cap_src),
      .filter_en (ctrl_b_reg[`TCC_NC_BIT]),
      .level_out (cap_lvl)
   );
   // Edge chosen by second control register
   wire cap_evt = ctrl_b_reg[`TCC_EDGE_BIT] ? (cap_lvl & ~cap_prev_reg) : (~cap_lvl & cap_prev_reg);

   // Clock select: stop, undivided, four prescaler taps, external edges
   logic tick;
   always_comb begin
      case (cs_f)
         3'h1:    tick = 1'b1;
         3'h2:    tick = &pre_reg[2:0];
         3'h3:    tick = &pre_reg[5:0];
         3'h4:    tick = &pre_reg[7:0];
         3'h5:    tick = &pre_reg[9:0];
         3'h6:    tick = ext_fall;
         3'h7:    tick = ext_rise;
         default: tick = 1'b0;
      endcase
   end

   wire [15:0] cmp_a   = pwm_on ? oca_buf_reg : oca_reg;
   wire [15:0] cmp_b   = pwm_on ? ocb_buf_reg : ocb_reg;
   wire        match_a = tick & (cnt_reg == cmp_a);
   wire        match_b = tick & (cnt_reg == cmp_b);
   wire        at_top  = (cnt_reg == top);
   wire        at_zero = (cnt_reg == 16'h0000);
   wire        ovf_evt = tick & (pwm_on ? (dir_reg == TCC_DOWN && at_zero) : at_top);

   // Counter next value and direction
   always_comb begin
      cnt_next = cnt_reg;
      dir_next = dir_reg;
      if (!pwm_on) begin
         dir_next = TCC_UP;
         if (tick) begin
            // Clear on compare A when enabled
            if (ctc_en && cnt_reg == oca_reg) begin
               cnt_next = 16'h0000;
            end else begin
               cnt_next = cnt_reg + 16'h0001;
            end
         end
      end else if (tick) begin
         case (dir_reg)
            TCC_UP: begin
               if (at_top) begin
                  dir_next = TCC_DOWN;
                  cnt_next = cnt_reg - 16'h0001;
               end else begin
                  cnt_next = cnt_reg + 16'h0001;
               end
            end
            TCC_DOWN: begin
               if (at_zero) begin
                  dir_next = TCC_UP;
                  cnt_next = cnt_reg + 16'h0001;
               end else begin
                  cnt_next = cnt_reg - 16'h0001;
               end
            end
            default: dir_next = TCC_UP;
         endcase
      end
      if (wr_cnt_l) begin
         cnt_next = wr_word;
      end
   end

   // Pin action for one compare channel
   function automatic logic pin_next(input logic cur, input logic [1:0] act, input logic pwm,
                                     input logic up);
      logic res;
      res = cur;
      if (pwm) begin
         // PWM: 10 clears up / sets down, 11 inverted
         case (act)
            TCC_ACT_LOW:  res = ~up;
            TCC_ACT_HIGH: res = up;
            default:      res = cur;
         endcase
      end else begin
         case (act)
            TCC_ACT_TOGGLE: res = ~cur;
            TCC_ACT_LOW:    res = 1'b0;
            TCC_ACT_HIGH:   res = 1'b1;
            default:        res = cur;
         endcase
      end
      return res;
   endfunction : pin_next

   wire up_now = (dir_reg == TCC_UP);

   // Event flags: hardware set wins over a write-one clear in the same cycle
   wire [7:0] set_vec = ({7'h00, ovf_evt} << `TCC_BIT_WIDE_OVF)
                      | ({7'h00, match_a} << `TCC_BIT_MATCH_A)
                      | ({7'h00, match_b} << `TCC_BIT_MATCH_B)
                      | ({7'h00, cap_evt} << `TCC_BIT_CAPTURE)
                      | ({7'h00, narrow_timer_overflow_evt} << `TCC_BIT_NARROW_OVF);
   wire [7:0] clr_vec = (wr & hit_flags) ? wbyte : 8'h00;
   assign flags_next = ((flags_reg & ~clr_vec) | set_vec) & `TCC_FLAGS_WMASK;

   // Unused positions never stored, so read zero
   logic [7:0] rd_byte;
   always_comb begin
      case (idx)
         `TCC_IDX_CTRL_A:   rd_byte = ctrl_a_reg;
         `TCC_IDX_CTRL_B:   rd_byte = ctrl_b_reg;
         `TCC_IDX_CNT_L:    rd_byte = cnt_reg[7:0];
         `TCC_IDX_CNT_H:    rd_byte = temp_reg;
         `TCC_IDX_OCA_L:    rd_byte = oca_reg[7:0];
         `TCC_IDX_OCA_H:    rd_byte = oca_reg[15:8];
         `TCC_IDX_OCB_L:    rd_byte = ocb_reg[7:0];
         `TCC_IDX_OCB_H:    rd_byte = ocb_reg[15:8];
         `TCC_IDX_CAP_L:    rd_byte = cap_reg[7:0];
         `TCC_IDX_CAP_H:    rd_byte = temp_reg;
         `TCC_IDX_PINDIR:   rd_byte = pindir_reg;
         `TCC_IDX_FLAGS:    rd_byte = flags_reg;
         `TCC_IDX_MASK:     rd_byte = mask_reg;
         `TCC_IDX_CPUFLAGS: rd_byte = {gie_reg, 7'h00};
         default:           rd_byte = 8'h00;
      endcase
   end
   // Snapshot of the high byte taken with the low byte, so both halves match
   wire [7:0] hi_snap = hit_cap_l ? cap_reg[15:8] : cnt_reg[15:8];

   // Bus-side register writes and read capture
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_a_reg <= `TCC_RESET_BYTE;
         ctrl_b_reg <= `TCC_RESET_BYTE;
         mask_reg   <= `TCC_RESET_BYTE;
         pindir_reg <= `TCC_RESET_BYTE;
         gie_reg    <= 1'b0;
         prdata     <= 32'h0000_0000;
         rd_hi_reg  <= 8'h00;
      end else begin
         if (wr && hit_ctrl_a) ctrl_a_reg <= wbyte & `TCC_CTRL_A_WMASK;
         if (wr && hit_ctrl_b) ctrl_b_reg <= wbyte & `TCC_CTRL_B_WMASK;
         if (wr && hit_mask) mask_reg <= wbyte & `TCC_MASK_WMASK;
         if (wr && hit_pindir) pindir_reg <= wbyte & `TCC_PINDIR_WMASK;
         if (wr && hit_cpufl) gie_reg <= wbyte[`TCC_BIT_GIE];
         if (setup && !pwrite) begin
            prdata    <= {24'h00_0000, rd_byte};
            rd_hi_reg <= hi_snap;
         end
      end
   end

   // Staging byte shared by all sixteen-bit registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         temp_reg <= 8'h00;
      end else if (wr_high) begin
         temp_reg <= wbyte;
      end else if (rd_lo_lat) begin
         temp_reg <= rd_hi_reg;
      end
   end

   // Compare registers; PWM copies are refreshed only at the top
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         oca_reg     <= 16'h0000;
         ocb_reg     <= 16'h0000;
         oca_buf_reg <= 16'h0000;
         ocb_buf_reg <= 16'h0000;
      end else begin
         if (wr_oca_l) oca_reg <= wr_word;
         if (wr_ocb_l) ocb_reg <= wr_word;
         // Glitch-free update at the period top
         if (!pwm_on || (tick && up_now && at_top)) begin
            oca_buf_reg <= oca_reg;
            ocb_buf_reg <= ocb_reg;
         end
      end
   end

   // Counter, prescaler, flags and capture
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg      <= 16'h0000;
         dir_reg      <= TCC_UP;
         pre_reg      <= '0;
         flags_reg    <= `TCC_RESET_BYTE;
         cap_reg      <= 16'h0000;
         ext_prev_reg <= 1'b0;
         cap_prev_reg <= 1'b0;
      end else begin
         cnt_reg      <= cnt_next;
         dir_reg      <= dir_next;
         pre_reg      <= pre_reg + 1'b1;
         flags_reg    <= flags_next;
         ext_prev_reg <= ext_lvl;
         cap_prev_reg <= cap_lvl;
         if (cap_evt) cap_reg <= cnt_reg;
      end
   end

   // Compare output latches
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         oa_reg <= 1'b0;
         ob_reg <= 1'b0;
      end else begin
         if (match_a) oa_reg <= pin_next(oa_reg, act_a, pwm_on, up_now);
         if (match_b) ob_reg <= pin_next(ob_reg, act_b, pwm_on, up_now);
      end
   end

   // Pin driven only with direction set to output
   assign match_a_pin_out  = oa_reg;
   assign match_b_pin_out  = ob_reg;
   assign match_a_pin_oe_n = ~(pindir_reg[0] & (act_a != TCC_ACT_NONE));
   assign match_b_pin_oe_n = ~(pindir_reg[1] & (act_b != TCC_ACT_NONE));

   // Flag AND mask AND global enable
   assign irq_wide_ovf   = gie_reg & mask_reg[`TCC_BIT_WIDE_OVF] & flags_reg[`TCC_BIT_WIDE_OVF];
   assign irq_match_a    = gie_reg & mask_reg[`TCC_BIT_MATCH_A] & flags_reg[`TCC_BIT_MATCH_A];
   assign irq_match_b    = gie_reg & mask_reg[`TCC_BIT_MATCH_B] & flags_reg[`TCC_BIT_MATCH_B];
   assign irq_capture    = gie_reg & mask_reg[`TCC_BIT_CAPTURE] & flags_reg[`TCC_BIT_CAPTURE];
   assign irq_narrow_ovf = gie_reg & mask_reg[`TCC_BIT_NARROW_OVF] & flags_reg[`TCC_BIT_NARROW_OVF];
endmodule : tcc_timer1_ctrl
`default_nettype wire

// >>> verification/tcc_pin_model.sv
// Far-side pin model: external count clock and capture input
`default_nettype none
module tcc_pin_model (
   input  wire logic pclk,
   output logic      external_count_pin,
   output logic      capture_input_pin
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      external_count_pin = 1'h0;
      capture_input_pin  = 1'h0;
   end

   // edges at least one clock apart
   task count_edges(input int n, input int gap);
      repeat (2 * n) begin
         @(posedge pclk);
         external_count_pin <= ~external_count_pin;
         repeat (gap - 1) @(posedge pclk);
      end
   endtask : count_edges

   // Short pulses exercise the capture filter
   task pulse(input int n);
      @(posedge pclk);
      capture_input_pin <= 1'h1;
      repeat (n) @(posedge pclk);
      capture_input_pin <= 1'h0;
   endtask : pulse
endmodule : tcc_pin_model
`default_nettype wire

// >>> verification/tcc_timer1_ctrl_chk.sv
// Port-level assertions for the timer control block
`default_nettype none
module tcc_timer1_ctrl_chk (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [9:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        irq_wide_ovf,
   input wire logic        irq_match_a,
   input wire logic        irq_match_b,
   input wire logic        irq_capture,
   input wire logic        irq_narrow_ovf
);
   timeunit 1ns;
   timeprecision 1ns;
   wire acc  = psel && penable;
   wire wr_m = acc && pwrite && paddr[9:2] == 8'h39;
   wire wr_g = acc && pwrite && paddr[9:2] == 8'h3f;
   wire rd_m = acc && !pwrite && paddr[9:2] == 8'h39;
   wire rd_c = acc && !pwrite && paddr[9:2] == 8'h2f;
   wire any  = irq_wide_ovf || irq_match_a || irq_match_b || irq_capture || irq_narrow_ovf;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   chk_wide_ovf_gate: assert property (wr_m && !pwdata[7] |=> !irq_wide_ovf)
      else $error("wide overflow request with its mask clear");
   chk_match_a_gate: assert property (wr_m && !pwdata[6] |=> !irq_match_a)
      else $error("match a request with its mask clear");
   chk_match_b_gate: assert property (wr_m && !pwdata[5] |=> !irq_match_b)
      else $error("match b request with its mask clear");
   chk_capture_gate: assert property (wr_m && !pwdata[3] |=> !irq_capture)
      else $error("capture request with its mask clear");
   chk_narrow_gate: assert property (wr_m && !pwdata[1] |=> !irq_narrow_ovf)
      else $error("narrow overflow request with its mask clear");
   chk_global_gate: assert property (wr_g && !pwdata[7] |=> !any [*2])
      else $error("request while global enable clear");
   chk_mask_reserved: assert property (rd_m |-> (prdata[7:0] & 8'h15) == 8'h00)
      else $error("mask reserved bits not zero");
   chk_ctrl_reserved: assert property (rd_c |-> prdata[3:2] == 2'h0)
      else $error("control reserved bits not zero");

   cover property (irq_wide_ovf);
   cover property (irq_match_a && irq_match_b);
   cover property (irq_capture);
endmodule : tcc_timer1_ctrl_chk

bind tcc_timer1_ctrl tcc_timer1_ctrl_chk i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .irq_wide_ovf, .irq_match_a, .irq_match_b, .irq_capture, .irq_narrow_ovf);
`default_nettype wire

// >>> verification/tcc_timer1_ctrl_tb_top.sv
// Self-checking bench for the timer compare/capture control block
`default_nettype none
module tcc_timer1_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        pclk, presetn, psel, penable, pwrite;
   logic [9:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic        pready, pslverr, comparator_out, narrow_timer_overflow_evt;
   logic        external_count_pin, capture_input_pin;
   logic        match_a_pin_out, match_a_pin_oe_n, match_b_pin_out, match_b_pin_oe_n;
   logic        irq_wide_ovf, irq_match_a, irq_match_b, irq_capture, irq_narrow_ovf;
   int          miscompares, total_checks;
   logic [7:0]  r;
   logic        e;

   tcc_timer1_ctrl #(.NC_DEPTH(4)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .external_count_pin, .capture_input_pin,
      .comparator_out, .narrow_timer_overflow_evt, .match_a_pin_out, .match_a_pin_oe_n,
      .match_b_pin_out, .match_b_pin_oe_n, .irq_wide_ovf, .irq_match_a, .irq_match_b,
      .irq_capture, .irq_narrow_ovf);
   tcc_pin_model i_pins (.pclk, .external_count_pin, .capture_input_pin);

   initial begin
      pclk = 1'h0;
      forever #20 pclk = ~pclk;
   end

   task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // Zero-wait slave, but the wait is still bounded rather than assumed
   task apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel    <= 1'h1;
      penable <= 1'h0;
      pwrite  <= w;
      paddr   <= {idx, 2'h0};
      pwdata  <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'h1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'h1 && n < 50);
      if (pready !== 1'h1) miscompares++;
      r = prdata[7:0];
      e = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
      @(negedge pclk);
   endtask : apb

   task wr(input logic [7:0] idx, input logic [7:0] d);
      apb(1'h1, idx, d);
   endtask : wr

   task rd(input string nm, input logic [7:0] idx, input logic [7:0] x);
      apb(1'h0, idx, 8'h00);
      chk(nm, {8'h0, r}, {8'h0, x});
   endtask : rd

   // Low byte first so the high byte comes from the staging snapshot
   task rd16(input string nm, input logic [7:0] lo, input logic [15:0] x);
      logic [7:0] l;
      apb(1'h0, lo, 8'h00);
      l = r;
      apb(1'h0, lo + 8'h01, 8'h00);
      chk(nm, {r, l}, x);
   endtask : rd16

   task wr16(input logic [7:0] hi, input logic [15:0] v);
      wr(hi, v[15:8]);
      wr(hi - 8'h01, v[7:0]);
   endtask : wr16

   task rst;
      presetn <= 1'h0;
      repeat (4) @(posedge pclk);
      presetn <= 1'h1;
   endtask : rst

   task t_regs;
      rd("ctrl a", 8'h2f, 8'h00);
      rd("mask", 8'h39, 8'h00);
      wr(8'h2f, 8'hff);
      rd("ctrl a", 8'h2f, 8'hf3);
      wr(8'h39, 8'hff);
      rd("mask", 8'h39, 8'hea);
      rd("unmapped", 8'h10, 8'h00);
      chk("slverr", {15'h0, e}, 16'h1);
      wr(8'h2f, 8'h00);
      wr(8'h39, 8'h00);
      $display("regs test done");
   endtask : t_regs

   task t_count;
      wr16(8'h2d, 16'h1234);
      rd16("count", 8'h2c, 16'h1234);
      wr16(8'h2d, 16'h0000);
      wr(8'h2e, 8'h07);
      i_pins.count_edges(3, 1);
      i_pins.count_edges(2, 3);
      repeat (6) @(posedge pclk);
      wr(8'h2e, 8'h00);
      rd16("ext count", 8'h2c, 16'h0005);
      wr(8'h38, 8'hff);
      wr16(8'h2d, 16'hfffa);
      wr(8'h2e, 8'h01);
      repeat (10) @(posedge pclk);
      wr(8'h2e, 8'h00);
      rd("flags", 8'h38, 8'he0);
      wr(8'h39, 8'h80);
      wr(8'h3f, 8'h80);
      chk("irq ovf", {15'h0, irq_wide_ovf}, 16'h1);
      wr(8'h3f, 8'h00);
      chk("irq ovf gie", {15'h0, irq_wide_ovf}, 16'h0);
      wr(8'h39, 8'h00);
      $display("count test done");
   endtask : t_count

   task t_match;
      wr(8'h38, 8'hff);
      wr16(8'h2d, 16'h0000);
      wr16(8'h2b, 16'h0005);
      wr16(8'h29, 16'h0003);
      wr(8'h31, 8'h03);
      wr(8'h39, 8'h60);
      wr(8'h3f, 8'h80);
      for (int k = 3; k > 1; k--) begin
         wr(8'h2f, {k[1:0], k[1:0], 4'h0});
         wr(8'h2e, 8'h09);
         repeat (20) @(posedge pclk);
         wr(8'h2e, 8'h00);
         chk("pin a", {15'h0, match_a_pin_out}, {15'h0, k[0]});
         chk("pin b", {15'h0, match_b_pin_out}, {15'h0, k[0]});
         chk("oe a", {15'h0, match_a_pin_oe_n}, 16'h0);
         chk("oe b", {15'h0, match_b_pin_oe_n}, 16'h0);
         chk("irq ab", {14'h0, irq_match_a, irq_match_b}, 16'h3);
      end
      wr(8'h31, 8'h00);
      chk("oe a off", {15'h0, match_a_pin_oe_n}, 16'h1);
      wr(8'h31, 8'h03);
      wr(8'h2f, 8'h00);
      chk("oe a none", {15'h0, match_a_pin_oe_n}, 16'h1);
      wr(8'h38, 8'hff);
      chk("irq ab clr", {14'h0, irq_match_a, irq_match_b}, 16'h0);
      wr(8'h39, 8'h00);
      $display("match test done");
   endtask : t_match

   task t_cap;
      wr(8'h38, 8'hff);
      wr16(8'h2d, 16'h0abc);
      wr(8'h2e, 8'hc0);
      wr(8'h39, 8'h08);
      i_pins.pulse(2);
      repeat (10) @(posedge pclk);
      rd("glitch", 8'h38, 8'h00);
      i_pins.pulse(8);
      repeat (4) @(posedge pclk);
      rd("cap flag", 8'h38, 8'h08);
      rd16("cap", 8'h24, 16'h0abc);
      chk("irq cap", {15'h0, irq_capture}, 16'h1);
      wr(8'h38, 8'hff);
      wr16(8'h2d, 16'h0def);
      wr(8'h2e, 8'hd0);
      @(posedge pclk);
      comparator_out <= 1'h1;
      repeat (12) @(posedge pclk);
      rd16("cmp cap", 8'h24, 16'h0def);
      wr(8'h39, 8'h00);
      $display("capture test done");
   endtask : t_cap

   task t_narrow;
      wr(8'h39, 8'h02);
      @(posedge pclk);
      narrow_timer_overflow_evt <= 1'h1;
      @(posedge pclk);
      narrow_timer_overflow_evt <= 1'h0;
      @(negedge pclk);
      chk("irq narrow", {15'h0, irq_narrow_ovf}, 16'h1);
      wr(8'h39, 8'h00);
      chk("irq narrow off", {15'h0, irq_narrow_ovf}, 16'h0);
      $display("narrow test done");
   endtask : t_narrow

   // Each mode restarts from reset so the count direction is known
   task t_pwm;
      int top;
      for (int m = 1; m < 4; m++) begin
         top = (256 << (m - 1)) - 1;
         rst();
         wr(8'h2f, 8'(m) | 8'h80);
         wr(8'h2e, 8'h01);
         repeat (top - 20) @(posedge pclk);
         apb(1'h0, 8'h38, 8'h00);
         chk("pwm ovf early", {15'h0, r[7]}, 16'h0);
         repeat (top + 40) @(posedge pclk);
         apb(1'h0, 8'h38, 8'h00);
         chk("pwm ovf", {15'h0, r[7]}, 16'h1);
         chk("pwm pin a", {15'h0, match_a_pin_out}, 16'h1);
      end
      $display("pwm test done");
   endtask : t_pwm

   task test_done;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : test_done

   initial begin
      {presetn, psel, penable, pwrite, comparator_out, narrow_timer_overflow_evt} = 6'h00;
      paddr = 10'h000;
      pwdata = 32'h0;
      miscompares = 0;
      total_checks = 0;
      rst();
      t_regs();
      t_count();
      t_match();
      t_cap();
      t_narrow();
      t_pwm();
      test_done();
   end

   initial begin
      repeat (20000) @(posedge pclk);
      miscompares++;
      test_done();
   end
endmodule : tcc_timer1_ctrl_tb_top
`default_nettype wire
